// [pkg/osw_pkg.sv]
// Purpose: constants shared by the oscillator switch request block
// Assumes: AXI4-Lite register access with 32-bit data, one word per register
// Notes: source codes flagged reserved are held in a mask so a part can differ
//
// Operation
// - software writes a 3-bit requested source and PLL choice in bits 6..4 of the request word.
// - software writes a 4-bit requested divider in bits 3..0 of the request word.
// - a write that carries a reserved source code is dropped whole, both fields kept.
// - while the switch write enable bit is 0 the request word is read-only and keeps its reset value.
// - at reset the requested divider is 0010 when the source is 110, else 0000.
// - at reset the requested source comes from the reset source fuse bits.
// - bit 7 of both words reads as zero and ignores writes.
// - the status word shows the active source in bits 6..4, read-only.
// - the status word shows the active divider in bits 3..0, read-only.
// - at reset the active fields equal the requested fields.
// - after power-on the status shows what is in effect when user code starts.
package osw_pkg;
    localparam logic [11:0] OSW_OFS_REQUEST = 12'h000;
    localparam logic [11:0] OSW_OFS_STATUS = 12'h004;
    localparam int OSW_SRC_W = 3;
    localparam int OSW_DIV_W = 4;
    localparam int OSW_SRC_LSB = 4;
    localparam int OSW_DIV_LSB = 0;
    localparam logic [2:0] OSW_SRC_HFINT_4M = 3'h6;
    localparam logic [3:0] OSW_DIV_RST_HFINT = 4'h2;
    localparam logic [3:0] OSW_DIV_RST_OTHER = 4'h0;
    localparam logic [7:0] OSW_SRC_RESERVED_MASK = 8'h18;
    localparam logic [1:0] OSW_RESP_OKAY = 2'h0;
    localparam logic [1:0] OSW_RESP_SLVERR = 2'h2;
    localparam logic [1:0] OSW_RESP_DECERR = 2'h3;
    localparam int OSW_SETTLE_CYCLES = 8;

    typedef enum logic [1:0] {
        OSW_ST_IDLE = 2'b00,
        OSW_ST_LOAD = 2'b01,
        OSW_ST_WAIT = 2'b10,
        OSW_ST_DONE = 2'b11
    } osw_state_t;

    // reset divider follows the reset source
    function automatic logic [3:0] osw_reset_div(input logic [2:0] src);
        osw_reset_div = (src == OSW_SRC_HFINT_4M) ? OSW_DIV_RST_HFINT : OSW_DIV_RST_OTHER;
    endfunction
endpackage

// [rtl/osw_sync.sv]
`timescale 1ns/1ns
// Purpose: three-stage synchroniser with agreement filter for pin levels
// Assumes: input is asynchronous to clk_i
// Notes: stage one feeds only stage two
module osw_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // level in and out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;

    // a change counts only once stages two and three agree
    always_comb begin
        out_nxt = out_r;
        if (s2_r == s3_r) begin
            out_nxt = s3_r;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign sync_o = out_r;
endmodule

// [rtl/osw_ctrl.sv]
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
// Purpose: oscillator source and postscaler request and status registers
// Assumes: fuse and enable straps are stable levels from the configuration array
// Notes: the straps are caught by a load cycle after reset release, not by the reset itself
module osw_ctrl
    import osw_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int SETTLE = OSW_SETTLE_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // configuration straps
    input wire logic [OSW_SRC_W-1:0] reset_source_fuse_i,
    input wire logic switch_write_enable_i,
    // clock generator handshake
    input wire logic osc_ready_i,
    output logic [OSW_SRC_W-1:0] clk_source_sel_o,
    output logic [OSW_DIV_W-1:0] clk_divider_sel_o,
    output logic switch_busy_o,
    output logic user_code_start_o,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [7:0] SETTLE_CNT = 8'(SETTLE);

    logic osc_ready_s;
    logic wen_s;
    logic [OSW_SRC_W-1:0] fuse_s;

    // straps and the oscillator ready flag come from outside this clock
    osw_sync #(
        .WIDTH(OSW_SRC_W + 2)
    ) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .async_i({osc_ready_i, switch_write_enable_i, reset_source_fuse_i}),
        .sync_o({osc_ready_s, wen_s, fuse_s})
    );

    // request, active and switch state
    osw_state_t state_r, state_nxt;
    logic [OSW_SRC_W-1:0] req_src_r, req_src_nxt;
    logic [OSW_DIV_W-1:0] req_div_r, req_div_nxt;
    logic [OSW_SRC_W-1:0] act_src_r, act_src_nxt;
    logic [OSW_DIV_W-1:0] act_div_r, act_div_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic wen_lock_r, wen_lock_nxt;
    logic pend_r, pend_nxt;

    // bus state
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic aw_have_r, aw_have_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic w_have_r, w_have_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic wr_fire;
    logic wr_hit_req;
    logic wr_hit_sts;
    logic [OSW_SRC_W-1:0] wr_src;
    logic [OSW_DIV_W-1:0] wr_div;
    logic wr_ok;

    // one write in flight; each channel is taken once and held until the response
    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
    assign wr_hit_req = (awaddr_r[ADDR_W-1:2] == OSW_OFS_REQUEST[ADDR_W-1:2]);
    assign wr_hit_sts = (awaddr_r[ADDR_W-1:2] == OSW_OFS_STATUS[ADDR_W-1:2]);
    assign wr_src = wdata_r[OSW_SRC_LSB +: OSW_SRC_W];
    assign wr_div = wdata_r[OSW_DIV_LSB +: OSW_DIV_W];
    // low byte lane must be enabled; source code must not be reserved
    assign wr_ok = wstrb_r[0] && !OSW_SRC_RESERVED_MASK[wr_src];

    // write and read channels
    always_comb begin
        awaddr_nxt = awaddr_r;
        aw_have_nxt = aw_have_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        w_have_nxt = w_have_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_nxt = s_axi_awaddr;
            aw_have_nxt = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
            w_have_nxt = 1'b1;
        end
        if (wr_fire) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            // read-only and ignored writes still answer okay, as a plain register would
            bresp_nxt = (wr_hit_req || wr_hit_sts) ? OSW_RESP_OKAY : OSW_RESP_DECERR;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = OSW_RESP_OKAY;
            rdata_nxt = '0; // bit 7 and above always read zero
            if (s_axi_araddr[ADDR_W-1:2] == OSW_OFS_REQUEST[ADDR_W-1:2]) begin
                rdata_nxt[OSW_SRC_LSB +: OSW_SRC_W] = req_src_r;
                rdata_nxt[OSW_DIV_LSB +: OSW_DIV_W] = req_div_r;
            end else if (s_axi_araddr[ADDR_W-1:2] == OSW_OFS_STATUS[ADDR_W-1:2]) begin
                rdata_nxt[OSW_SRC_LSB +: OSW_SRC_W] = act_src_r;
                rdata_nxt[OSW_DIV_LSB +: OSW_DIV_W] = act_div_r;
            end else begin
                rresp_nxt = OSW_RESP_DECERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            awaddr_r <= '0;
            aw_have_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= OSW_RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= OSW_RESP_OKAY;
            rdata_r <= '0;
        end else begin
            awaddr_r <= awaddr_nxt;
            aw_have_r <= aw_have_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            w_have_r <= w_have_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // switch sequencer: load straps after release, then track requests
    always_comb begin
        state_nxt = state_r;
        req_src_nxt = req_src_r;
        req_div_nxt = req_div_r;
        act_src_nxt = act_src_r;
        act_div_nxt = act_div_r;
        cnt_nxt = cnt_r;
        wen_lock_nxt = wen_lock_r;
        pend_nxt = pend_r;
        case (state_r)
            OSW_ST_LOAD: begin
                // wait for the synchroniser to settle before trusting the straps
                if (cnt_r == SETTLE_CNT) begin
                    req_src_nxt = fuse_s;
                    req_div_nxt = osw_reset_div(fuse_s);
                    act_src_nxt = fuse_s;
                    act_div_nxt = osw_reset_div(fuse_s);
                    wen_lock_nxt = wen_s;
                    cnt_nxt = '0;
                    state_nxt = OSW_ST_IDLE; // user code may start now
                end else begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            OSW_ST_IDLE: begin
                if (pend_r) begin
                    pend_nxt = 1'b0;
                    state_nxt = OSW_ST_WAIT;
                end
            end
            OSW_ST_WAIT: begin
                // active fields move only once the new source reports running
                if (osc_ready_s) begin
                    state_nxt = OSW_ST_DONE;
                end
            end
            OSW_ST_DONE: begin
                act_src_nxt = req_src_r;
                act_div_nxt = req_div_r;
                state_nxt = OSW_ST_IDLE;
            end
            default: begin
                state_nxt = OSW_ST_LOAD;
            end
        endcase
        // a request written mid-switch is taken up by the next switch
        if (wr_fire && wr_hit_req && wr_ok && wen_lock_r && state_r != OSW_ST_LOAD) begin
            req_src_nxt = wr_src;
            req_div_nxt = wr_div;
            pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= OSW_ST_LOAD;
            req_src_r <= '0;
            req_div_r <= '0;
            act_src_r <= '0;
            act_div_r <= '0;
            cnt_r <= '0;
            wen_lock_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            req_src_r <= req_src_nxt;
            req_div_r <= req_div_nxt;
            act_src_r <= act_src_nxt;
            act_div_r <= act_div_nxt;
            cnt_r <= cnt_nxt;
            wen_lock_r <= wen_lock_nxt;
            pend_r <= pend_nxt;
        end
    end

    // outputs
    assign clk_source_sel_o = req_src_r;
    assign clk_divider_sel_o = req_div_r;
    assign switch_busy_o = (state_r == OSW_ST_WAIT) || (state_r == OSW_ST_DONE) || pend_r;
    assign user_code_start_o = (state_r != OSW_ST_LOAD);
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
endmodule

// [tb/osw_ctrl_props.sv]
// Purpose: port-level checks for the oscillator switch request block
// Assumes: bound to osw_ctrl, one clock domain
// Notes: only relations visible at the ports are checked here
`timescale 1ns/1ns
module osw_ctrl_props
    import osw_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int SETTLE = OSW_SETTLE_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // status and selection
    input wire logic user_code_start_o,
    input wire logic [OSW_SRC_W-1:0] clk_source_sel_o,
    input wire logic [OSW_DIV_W-1:0] clk_divider_sel_o,
    // write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    // read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // both halves of a write taken together
    wire wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    // once user code runs it keeps running until the next reset
    start_hold_a: assert property (
        user_code_start_o |=> user_code_start_o)
        else $error("start flag dropped");
    rdata_high_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
        else $error("read data above bit 6 not zero");
    wr_answer_a: assert property (
        wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (
        rd_take |=> s_axi_rvalid)
        else $error("read response late");
    rd_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    unmapped_a: assert property (
        rd_take && s_axi_araddr[ADDR_W-1:2] > 1
        |=> s_axi_rresp == OSW_RESP_DECERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    // a reserved source code leaves both requested fields alone
    reserved_drop_a: assert property (
        wr_both && s_axi_awaddr == OSW_OFS_REQUEST && s_axi_wdata[6:4] inside {3'h3, 3'h4}
        |-> ##1 ($stable(clk_source_sel_o) && $stable(clk_divider_sel_o))[*3])
        else $error("reserved source write took effect");
    sel_cause_a: assert property (
        user_code_start_o && $past(user_code_start_o)
        && ($changed(clk_source_sel_o) || $changed(clk_divider_sel_o))
        |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("selection changed without a write");
endmodule
bind osw_ctrl osw_ctrl_props #(.ADDR_W(ADDR_W), .SETTLE(SETTLE)) u_props (.*);

// [tb/tb_oscillator_switch_request.sv]
// Purpose: self-checking bench for the oscillator switch request block
// Assumes: register access over AXI4-Lite, fast oscillator ready by default
// Notes: SETTLE shortened to 4 to keep the load phase brief
`timescale 1ns/1ns
module tb_oscillator_switch_request;
    import osw_pkg::*;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic [7:0] e;} osw_row_t;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [2:0] fuse = 3'h6;
    logic wen = 1'b1;
    logic rdy = 1'b1;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, busy, start;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] sel_src;
    logic [3:0] sel_div;
    logic [3:0] wstrb = 4'hf;
    logic [31:0] got;
    int fails = 0;
    int n_compared = 0;
    // writes, some with reserved source codes or to the status word: address, data, expected request word afterwards
    osw_row_t rows [6] = '{'{12'h000, 32'h0000_0025, 8'h25}, '{12'h000, 32'h0000_00ff, 8'h7f},
        '{12'h000, 32'h0000_003a, 8'h7f}, '{12'h000, 32'h0000_0041, 8'h7f},
        '{12'h004, 32'h0000_0000, 8'h7f}, '{12'h000, 32'h0000_0050, 8'h50}};
    always #4 clk_i = ~clk_i;
    osw_ctrl #(.SETTLE(4)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .reset_source_fuse_i(fuse), .switch_write_enable_i(wen), .osc_ready_i(rdy),
        .clk_source_sel_o(sel_src), .clk_divider_sel_o(sel_div), .switch_busy_o(busy),
        .user_code_start_o(start), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ready is sampled at the falling edge, so it is settled and holds to the next rise
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, ta, tw;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk_i);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(aw && w)) begin
            @(negedge clk_i);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge clk_i);
            if (ta) begin awvalid <= 1'b0; aw = 1'b1; end
            if (tw) begin wvalid <= 1'b0; w = 1'b1; end
        end
        do @(negedge clk_i); while (!bvalid);
        r = bresp;
        @(posedge clk_i);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge clk_i); while (!arready);
        @(posedge clk_i);
        arvalid <= 1'b0;
        // rready comes a cycle late so the slave must hold its answer
        do @(negedge clk_i); while (!rvalid);
        @(posedge clk_i);
        rready <= 1'b1;
        @(negedge clk_i);
        d = rdata;
        r = rresp;
        @(posedge clk_i);
        rready <= 1'b0;
    endtask
    // reset with given straps, then wait for the load phase to finish
    task automatic rst(input logic [2:0] f, input logic we);
        @(posedge clk_i);
        resetn_i <= 1'b0; fuse <= f; wen <= we;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        do @(negedge clk_i); while (!start);
    endtask
    // hang guard, well above the 150 or so cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        complete_run();
    end
    initial begin
        rst(3'h6, 1'b1);
        rd(12'h000, got, resp); chk(got, 32'h62);
        rd(12'h004, got, resp); chk(got, 32'h62);
        $display("reset defaults done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, resp); chk(resp, OSW_RESP_OKAY);
            rd(12'h000, got, resp); chk(got, rows[i].e);
            chk({sel_src, sel_div}, rows[i].e[6:0]);
            do @(negedge clk_i); while (busy);
            rd(12'h004, got, resp); chk(got, rows[i].e);
        end
        $display("row table done");
        // slow oscillator: status must wait for ready
        @(posedge clk_i);
        rdy <= 1'b0;
        wr(12'h000, 32'h0000_0021, resp);
        repeat (3) @(negedge clk_i);
        chk(busy, 1'b1);
        rd(12'h004, got, resp); chk(got, 32'h50);
        rdy <= 1'b1;
        do @(negedge clk_i); while (busy);
        rd(12'h004, got, resp); chk(got, 32'h21);
        rd(12'h008, got, resp); chk(resp, OSW_RESP_DECERR); chk(got, 32'h0);
        // low byte lane disabled: the request word must not move
        wstrb <= 4'he;
        wr(12'h000, 32'h0000_0025, resp);
        rd(12'h000, got, resp); chk(got, 32'h21);
        wstrb <= 4'hf;
        $display("slow switch and unmapped done");
        // second reset, other fuse, writes locked
        rst(3'h1, 1'b0);
        rd(12'h000, got, resp); chk(got, 32'h10);
        wr(12'h000, 32'h0000_0025, resp);
        rd(12'h000, got, resp); chk(got, 32'h10);
        rd(12'h004, got, resp); chk(got, 32'h10);
        $display("locked reset done");
        complete_run();
    end
endmodule
